// file: rtl/pdc_defines.svh
// timing counts, register offsets and field positions for the detector control block
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// system clock
`define PDC_CLK_PERIOD_NS      40
// soft restart window after leaving power save (least time, rounds up)
`define PDC_SOFT_WINDOW_NS     4000
`define PDC_SOFT_WINDOW_CYC    ((`PDC_SOFT_WINDOW_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS)
// longest pump pulse allowed inside the soft window (longest time, rounds down)
`define PDC_SOFT_PULSE_NS      120
`define PDC_SOFT_PULSE_CYC     (`PDC_SOFT_PULSE_NS / `PDC_CLK_PERIOD_NS)
// quiet cycles before lock is reported
`define PDC_LOCK_CYC_RST       8'h10

// serial word
`define PDC_SHIFT_LEN          19
`define PDC_TGT_BIT            0

// register byte offsets
`define PDC_ADR_REF            4'h0
`define PDC_ADR_MAIN           4'h4
`define PDC_ADR_STATUS         4'h8
`define PDC_ADR_CTRL           4'hC

// control register fields
`define PDC_CTRL_LOCK_LSB      0
`define PDC_CTRL_PULSE_LSB     8

// status register fields
`define PDC_ST_SAVE            0
`define PDC_ST_SOFT            1
`define PDC_ST_LOCK            2
`define PDC_ST_UP              3
`define PDC_ST_DOWN            4
`define PDC_ST_PUMP_EN         5

`endif

// file: rtl/pdc_pkg.sv
// types shared by the detector control block
package pdc_pkg;

	// reference divider word, msb first as it sits in the shift register
	typedef struct packed {
		logic        pumpCurrentHigh;
		logic        monitor_select;
		logic        phase_polarity;
		logic        prescalerLow;
		logic [13:0] refRatio;
		logic        target_select;
	} pdc_ref_word_t;

	// main divider word
	typedef struct packed {
		logic [10:0] progCount;
		logic [6:0]  swallowCount;
		logic        target_select;
	} pdc_main_word_t;

	// a driven pin: level plus enable
	typedef struct packed {
		logic oe;
		logic out;
	} pdc_tri_t;

	// power state, gray along save -> soft -> run
	typedef enum logic [1:0] {
		PDC_SAVE = 2'b00,
		PDC_SOFT = 2'b01,
		PDC_RUN  = 2'b11
	} pdc_pwr_t;

endpackage : pdc_pkg

// file: rtl/pdc_sync.sv
// two flip-flop synchroniser for a group of level signals
`timescale 1ns/1ns
`default_nettype none

module pdc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;

	// first stage feeds only the second; resets low so power save holds at start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_q <= '0;
			syncOut  <= '0;
		end else begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end

endmodule : pdc_sync

`default_nettype wire

// file: rtl/pdc_top.sv
// phase detector output control, power save, soft restart and serial load
// How it works
// - monitor pin shows frequency or lock detect
// - polarity bit inverts pump and comparator outputs
// - polarity high output table for pump, comparators
// - polarity low output table, mirrored
// - frequency monitor shows reference or comparison by polarity
// - pump enable pin low floats the pump
// - power save pin low enters saving mode
// - saving mode floats the pump output
// - saving mode forces lock detect high
// - power save pin high returns normal mode
// - after saving, pump error pulses are limited
// - serial clock rising edge shifts one bit
// - strobe rise latches word by target bit
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

`include "pdc_defines.svh"

module pdc_top #(
	parameter int LOCK_W  = 8,
	parameter int PULSE_W = 8,
	parameter int SOFT_W  = 12
) (
	// system clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// wishbone slave
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	input  wire logic                   we_i,
	input  wire logic [3:0]             adr_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic [31:0]            dat_i,
	output logic      [31:0]            dat_o,
	output logic                        ack_o,
	// serial link, on its own clock
	input  wire logic                   serialClk,
	input  wire logic                   serialData,
	input  wire logic                   load_strobe,
	// control pins
	input  wire logic                   power_save_n,
	input  wire logic                   pump_output_enable,
	// divided frequencies from the dividers
	input  wire logic                   ref_freq,
	input  wire logic                   cmp_freq,
	// detector outputs
	output pdc_pkg::pdc_tri_t           pumpPin,
	output logic                        refPhaseOut,
	output pdc_pkg::pdc_tri_t           cmpPhasePin,
	output logic                        monitorOut,
	// divider settings
	output pdc_pkg::pdc_ref_word_t      refWord,
	output pdc_pkg::pdc_main_word_t     mainWord
);

	////////////////////////////////////////////////////////////////////////
	// serial link domain
	logic [`PDC_SHIFT_LEN-1:0] shift_q;

	// one bit per rising serial clock edge, first bit ends at the top
	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
		end else begin
			shift_q <= {shift_q[`PDC_SHIFT_LEN-2:0], serialData};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic psSync;
	logic pumpEnSync;
	logic strobeSync;
	logic refSync;
	logic cmpSync;

	// sync resets low, so the block starts in power save until the pin rises
	pdc_sync #(.WIDTH(5)) u_pinSync (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({power_save_n, pump_output_enable, load_strobe, ref_freq, cmp_freq}),
		.syncOut ({psSync, pumpEnSync, strobeSync, refSync, cmpSync})
	);

	////////////////////////////////////////////////////////////////////////
	// edge detection on synchronised levels
	logic strobe_q;
	logic ref_q;
	logic cmp_q;
	logic strobeRise;
	logic refEdge;
	logic cmpEdge;

	// previous levels for rising edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobe_q <= 1'b0;
			ref_q    <= 1'b0;
			cmp_q    <= 1'b0;
		end else begin
			strobe_q <= strobeSync;
			ref_q    <= refSync;
			cmp_q    <= cmpSync;
		end
	end

	assign strobeRise = strobeSync & ~strobe_q;
	assign refEdge    = refSync & ~ref_q;
	assign cmpEdge    = cmpSync & ~cmp_q;

	////////////////////////////////////////////////////////////////////////
	// word latch
	// shift register is still while the strobe is high, so its edge qualifies the word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refWord  <= '0;
			mainWord <= '0;
		end else if (strobeRise) begin
			if (shift_q[`PDC_TGT_BIT]) begin
				refWord <= pdc_pkg::pdc_ref_word_t'(shift_q);
			end else begin
				mainWord <= pdc_pkg::pdc_main_word_t'(shift_q);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register
	logic [LOCK_W-1:0]  lockThresh_q;
	logic [PULSE_W-1:0] pulseMax_q;
	logic               busHit;
	logic               busWrite;

	assign busHit   = cyc_i & stb_i & ~ack_o;
	// a write lands on the edge at which the master sees ack, not before
	assign busWrite = cyc_i & stb_i & ack_o & we_i & (adr_i == `PDC_ADR_CTRL);

	// lock threshold and soft pulse limit, byte lanes honoured
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lockThresh_q <= LOCK_W'(`PDC_LOCK_CYC_RST);
			pulseMax_q   <= PULSE_W'(`PDC_SOFT_PULSE_CYC);
		end else if (busWrite) begin
			if (sel_i[0]) begin
				lockThresh_q <= dat_i[`PDC_CTRL_LOCK_LSB +: LOCK_W];
			end
			if (sel_i[1]) begin
				pulseMax_q <= dat_i[`PDC_CTRL_PULSE_LSB +: PULSE_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power state machine
	pdc_pkg::pdc_pwr_t pwr_q;
	logic [SOFT_W-1:0] softCnt_q;
	logic              saving;
	logic              softStart;

	// pin low always wins; release goes through a soft window first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwr_q     <= pdc_pkg::PDC_SAVE;
			softCnt_q <= '0;
		end else begin
			case (pwr_q)
				pdc_pkg::PDC_SAVE: begin
					if (psSync) begin
						pwr_q     <= pdc_pkg::PDC_SOFT;
						softCnt_q <= SOFT_W'(`PDC_SOFT_WINDOW_CYC - 1);
					end
				end
				pdc_pkg::PDC_SOFT: begin
					if (!psSync) begin
						pwr_q <= pdc_pkg::PDC_SAVE;
					end else if (softCnt_q == '0) begin
						pwr_q <= pdc_pkg::PDC_RUN;
					end else begin
						softCnt_q <= softCnt_q - SOFT_W'(1);
					end
				end
				pdc_pkg::PDC_RUN: begin
					if (!psSync) begin
						pwr_q <= pdc_pkg::PDC_SAVE;
					end
				end
				default: begin
					pwr_q <= pdc_pkg::PDC_SAVE;
				end
			endcase
		end
	end

	assign saving    = (pwr_q == pdc_pkg::PDC_SAVE);
	assign softStart = (pwr_q == pdc_pkg::PDC_SOFT);

	////////////////////////////////////////////////////////////////////////
	// phase frequency detector
	logic up_q;
	logic dn_q;
	logic upNext;
	logic dnNext;

	assign upNext = up_q | refEdge;
	assign dnNext = dn_q | cmpEdge;

	// state is cleared in save so the restart begins from no error
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end else if (saving || (upNext && dnNext)) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end else begin
			up_q <= upNext;
			dn_q <= dnNext;
		end
	end

	// reference faster raises up, slower raises down; polarity swaps the sense
	logic refFaster;
	logic refSlower;
	logic effUp;
	logic effDn;

	assign refFaster = up_q & ~dn_q;
	assign refSlower = dn_q & ~up_q;
	assign effUp     = refWord.phase_polarity ? refFaster : refSlower;
	assign effDn     = refWord.phase_polarity ? refSlower : refFaster;

	////////////////////////////////////////////////////////////////////////
	// soft restart pulse limiter
	logic [PULSE_W-1:0] errCnt_q;
	logic               pulseCut;

	// counts how long the present error pulse has lasted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			errCnt_q <= '0;
		end else if (!(effUp || effDn)) begin
			errCnt_q <= '0;
		end else if (errCnt_q != '1) begin
			errCnt_q <= errCnt_q + PULSE_W'(1);
		end
	end

	// a long pulse right after wake would kick the vco far off frequency
	assign pulseCut = softStart && (errCnt_q >= pulseMax_q);

	////////////////////////////////////////////////////////////////////////
	// lock detector
	logic [LOCK_W-1:0] quietCnt_q;
	logic              lock_q;

	// lock once the detector has been quiet for the threshold
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quietCnt_q <= '0;
			lock_q     <= 1'b1;
		end else if (saving) begin
			quietCnt_q <= '0;
			lock_q     <= 1'b1;
		end else if (effUp || effDn) begin
			quietCnt_q <= '0;
			lock_q     <= 1'b0;
		end else if (quietCnt_q >= lockThresh_q) begin
			lock_q <= 1'b1;
		end else begin
			quietCnt_q <= quietCnt_q + LOCK_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// detector output pins
	// pump: high on effective up, low on effective down, else floating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pumpPin <= '0;
		end else if (saving) begin
			pumpPin <= '0;
		end else if (!pumpEnSync) begin
			pumpPin <= '0;
		end else if (pulseCut) begin
			pumpPin <= '0;
		end else begin
			pumpPin.oe  <= effUp | effDn;
			pumpPin.out <= effUp;
		end
	end

	// reference line high on effective down; comparison line pulled low on effective up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refPhaseOut <= 1'b0;
			cmpPhasePin <= '0;
		end else begin
			refPhaseOut     <= effDn;
			cmpPhasePin.oe  <= effUp;
			cmpPhasePin.out <= 1'b0;
		end
	end

	// monitor pin: divided frequency or lock detect
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			monitorOut <= 1'b1;
		end else if (refWord.monitor_select) begin
			monitorOut <= refWord.phase_polarity ? refSync : cmpSync;
		end else begin
			monitorOut <= lock_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone read and acknowledge
	logic [31:0] status;
	logic [31:0] ctrlRead;
	logic [31:0] readMux;

	always_comb begin
		status                     = '0;
		status[`PDC_ST_SAVE]       = saving;
		status[`PDC_ST_SOFT]       = softStart;
		status[`PDC_ST_LOCK]       = lock_q;
		status[`PDC_ST_UP]         = effUp;
		status[`PDC_ST_DOWN]       = effDn;
		status[`PDC_ST_PUMP_EN]    = pumpEnSync;
		ctrlRead                   = '0;
		ctrlRead[`PDC_CTRL_LOCK_LSB +: LOCK_W]   = lockThresh_q;
		ctrlRead[`PDC_CTRL_PULSE_LSB +: PULSE_W] = pulseMax_q;
	end

	// unmapped offsets read as zero and are still acknowledged
	always_comb begin
		case (adr_i)
			`PDC_ADR_REF:    readMux = 32'(refWord);
			`PDC_ADR_MAIN:   readMux = 32'(mainWord);
			`PDC_ADR_STATUS: readMux = status;
			`PDC_ADR_CTRL:   readMux = ctrlRead;
			default:         readMux = 32'h0000_0000;
		endcase
	end

	// one wait state: ack the cycle after the request, drop it next cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= busHit;
			if (busHit && !we_i) begin
				dat_o <= readMux;
			end
		end
	end

endmodule : pdc_top

`default_nettype wire

// file: tb/pdc_chk.sv
// port assertions for the detector control block
`timescale 1ns/1ns
`default_nettype none

module pdc_chk (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// bus handshake
	input wire logic                   cyc_i,
	input wire logic                   stb_i,
	input wire logic                   ack_o,
	// pins
	input wire logic                   power_save_n,
	input wire logic                   pump_output_enable,
	input wire pdc_pkg::pdc_tri_t      pumpPin,
	input wire logic                   refPhaseOut,
	input wire pdc_pkg::pdc_tri_t      cmpPhasePin,
	input wire logic                   monitorOut,
	input wire pdc_pkg::pdc_ref_word_t refWord
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// bus answer one cycle after the take, pulse only
	AST_ACK_LATENCY: assert property (cyc_i && stb_i && !ack_o |=> ack_o) // bus handshake
		else $error("no ack one cycle after request");
	AST_ACK_SINGLE: assert property (ack_o |=> !ack_o) // bus handshake
		else $error("ack longer than one cycle");
	// five cycles cover synchroniser, state and output flop; lock needs one more
	property saveLockP;
		(!power_save_n && !refWord.monitor_select) [*6] |-> monitorOut;
	endproperty
	AST_SAVE_FLOAT: assert property (!power_save_n [*5] |-> !pumpPin.oe)
		else $error("pump driven in power save");
	AST_SAVE_LOCK: assert property (saveLockP)
		else $error("lock detect low in power save");
	AST_PUMP_GATE: assert property (!pump_output_enable [*5] |-> !pumpPin.oe)
		else $error("pump driven while disabled");
	AST_CMP_LEVEL: assert property (cmpPhasePin.oe |-> !cmpPhasePin.out)
		else $error("comparison output driven high");
	AST_CMP_EXCL: assert property (refPhaseOut |-> !cmpPhasePin.oe)
		else $error("both comparator outputs active");
	// in either polarity, pump high goes with both comparator lines low,
	// pump low with the reference line high and the comparison line floating
	property pumpHighP;
		pumpPin.oe && pumpPin.out |-> cmpPhasePin.oe && !refPhaseOut;
	endproperty
	property pumpLowP;
		pumpPin.oe && !pumpPin.out |-> refPhaseOut && !cmpPhasePin.oe;
	endproperty
	AST_PUMP_FWD: assert property (pumpHighP)
		else $error("comparator outputs disagree with pump");
	AST_PUMP_REV: assert property (pumpLowP)
		else $error("comparator outputs disagree with pump");

	// main scenarios reached
	cover property ($rose(pumpPin.oe));
	cover property ($rose(refPhaseOut));
	cover property (ack_o && cyc_i);
	cover property ($changed(refWord));
endmodule : pdc_chk

bind pdc_top pdc_chk chk (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.power_save_n(power_save_n), .pump_output_enable(pump_output_enable), .pumpPin(pumpPin),
	.refPhaseOut(refPhaseOut), .cmpPhasePin(cmpPhasePin), .monitorOut(monitorOut),
	.refWord(refWord));

`default_nettype wire

// file: tb/pdc_host.sv
// serial link partner: shifts words on its own clock, then strobes the latch
`timescale 1ns/1ns
`default_nettype none

module pdc_host (
	// serial link
	output var logic serialClk,
	output var logic serialData,
	output var logic load_strobe
);
	// link clock stands still low between frames
	initial begin
		serialClk = 1'h0;
		serialData = 1'h0;
		load_strobe = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// 15 ns link clock, msb first, strobe held low while shifting
	task automatic sendWord(input logic [18:0] w);
		for (int i = 18; i >= 0; i--) begin
			serialData = w[i];
			#8 serialClk = 1'h1;
			#7 serialClk = 1'h0;
		end
		serialData = ~serialData; // released line must not look like a held bit
		#20 load_strobe = 1'h1;
		#200 load_strobe = 1'h0;
		#20;
	endtask : sendWord
endmodule : pdc_host

`default_nettype wire

// file: tb/test_pdc_top.sv
// self-checking bench for the detector control block
`timescale 1ns/1ns
`default_nettype none

`include "pdc_defines.svh"

module test_pdc_top;
	// clock, reset, bus
	logic                    clk = 1'h0;
	logic                    rst = 1'h1;
	logic                    cyc_i = 1'h0;
	logic                    stb_i = 1'h0;
	logic                    we_i = 1'h0;
	logic [3:0]              adr_i = 4'h0;
	logic [3:0]              sel_i = 4'h0;
	logic [31:0]             dat_i = 32'h0;
	logic [31:0]             dat_o;
	logic                    ack_o;
	// link and pins
	logic                    serialClk;
	logic                    serialData;
	logic                    load_strobe;
	logic                    power_save_n = 1'h0;
	logic                    pump_output_enable = 1'h1;
	logic                    ref_freq = 1'h0;
	logic                    cmp_freq = 1'h0;
	pdc_pkg::pdc_tri_t       pumpPin;
	pdc_pkg::pdc_tri_t       cmpPhasePin;
	logic                    refPhaseOut;
	logic                    monitorOut;
	pdc_pkg::pdc_ref_word_t  refWord;
	pdc_pkg::pdc_main_word_t mainWord;
	// model and observers
	int                      err_count = 0;
	int                      comparisons = 0;
	int                      seed = 94214;
	int                      refPer = 20;
	int                      cmpPer = 28;
	int                      refCnt = 0;
	int                      cmpCnt = 0;
	int                      fwdCnt = 0;
	int                      revCnt = 0;
	int                      monRise = 0;
	int                      run = 0;
	int                      maxRun = 0;
	int                      phR = 0;
	int                      phP = 0;
	logic                    dir = 1'h1;
	logic                    clr = 1'h0;
	logic                    monQ = 1'h1;
	logic [18:0]             w;
	logic [18:0]             sentQ[$];
	logic [31:0]             rd;
	pdc_pkg::pdc_ref_word_t  rw;

	always #20 clk = ~clk;

	pdc_top uut (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .serialClk(serialClk),
		.serialData(serialData), .load_strobe(load_strobe), .power_save_n(power_save_n),
		.pump_output_enable(pump_output_enable), .ref_freq(ref_freq), .cmp_freq(cmp_freq),
		.pumpPin(pumpPin), .refPhaseOut(refPhaseOut), .cmpPhasePin(cmpPhasePin),
		.monitorOut(monitorOut), .refWord(refWord), .mainWord(mainWord));
	pdc_host host (.serialClk(serialClk), .serialData(serialData), .load_strobe(load_strobe));

	////////////////////////////////////////////////////////////////////////
	// divided frequencies, realigned on every clear so equal periods meet in phase
	always @(posedge clk) begin
		refCnt <= clr ? 0 : (refCnt + 1) % refPer;
		cmpCnt <= clr ? 0 : (cmpCnt + 1) % cmpPer;
		ref_freq <= refCnt < refPer / 2;
		cmp_freq <= cmpCnt < cmpPer / 2;
	end

	// pump direction, longest driven run and monitor rises since the last clear
	always @(posedge clk) begin
		monQ <= monitorOut;
		run <= (pumpPin.oe === 1'h1) ? run + 1 : 0;
		if (clr) begin
			fwdCnt <= 0;
			revCnt <= 0;
			monRise <= 0;
			maxRun <= 0;
			phR <= 0;
			phP <= 0;
		end else begin
			phR <= phR + (refPhaseOut === 1'h1);
			phP <= phP + (cmpPhasePin.oe === 1'h1);
			fwdCnt <= fwdCnt + (pumpPin.oe === 1'h1 && pumpPin.out === dir);
			revCnt <= revCnt + (pumpPin.oe === 1'h1 && pumpPin.out === ~dir);
			monRise <= monRise + (monitorOut === 1'h1 && monQ === 1'h0);
			if (run > maxRun) maxRun <= run;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// classic cycle: hold until ack is sampled, take data at that edge, then release
	task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
		@(posedge clk);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= we;
		adr_i <= adr;
		sel_i <= we ? 4'h1 : 4'hF;
		dat_i <= wd;
		// no cycle count assumed: only the watchdog ends a missing answer
		do @(posedge clk); while (ack_o !== 1'h1);
		chk(ack_o, 32'h1, "ack");
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask : xfer

	// last word latched for a target, from the queue of words sent
	function automatic logic [18:0] expOf(input logic t);
		expOf = 19'h0;
		foreach (sentQ[i]) if (sentQ[i][0] == t) expOf = sentQ[i];
	endfunction : expOf

	task automatic sendW(input logic [18:0] v);
		host.sendWord(v);
		sentQ.push_back(v);
		repeat (4) @(posedge clk);
		chk(refWord, expOf(1'h1), "ref word");
		chk(mainWord, expOf(1'h0), "main word");
	endtask : sendW

	task automatic window(input int n);
		@(posedge clk);
		clr <= 1'h1;
		@(posedge clk);
		clr <= 1'h0;
		repeat (n) @(posedge clk);
	endtask : window

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	// main sequence; power save stays low well past 1 us at start
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		xfer(1'h0, `PDC_ADR_CTRL, 32'h0);
		chk(rd, 32'h0000_0310, "ctrl reset");
		xfer(1'h1, `PDC_ADR_CTRL, 32'hFFFF_FF08);
		xfer(1'h0, `PDC_ADR_CTRL, 32'h0);
		chk(rd, 32'h0000_0308, "ctrl byte lane");
		xfer(1'h1, `PDC_ADR_REF, 32'hFFFF_FFFF);
		xfer(1'h0, `PDC_ADR_REF, 32'h0);
		chk(rd, 32'h0, "read only ref");
		xfer(1'h0, 4'h2, 32'h0);
		chk(rd, 32'h0, "unmapped");
		xfer(1'h0, `PDC_ADR_STATUS, 32'h0);
		chk(rd[`PDC_ST_SAVE], 32'h1, "save at start");
		chk(monitorOut, 32'h1, "lock at start");
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			w = 19'($random(seed));
			w[0] = k[0];
			sendW(w);
			xfer(1'h0, k[0] ? `PDC_ADR_REF : `PDC_ADR_MAIN, 32'h0);
			chk(rd, {13'h0, w}, "word register");
		end
		$display("test serial done");
		power_save_n <= 1'h1;
		window(90);
		chk(maxRun <= `PDC_SOFT_PULSE_CYC, 32'h1, "soft pulse cap");
		xfer(1'h0, `PDC_ADR_STATUS, 32'h0);
		chk(rd[`PDC_ST_SAVE], 32'h0, "normal mode");
		window(300);
		chk(maxRun > `PDC_SOFT_PULSE_CYC, 32'h1, "full pulses later");
		$display("test soft restart done");
		// polarity by faster side, then equal periods last
		for (int i = 0; i < 5; i++) begin
			rw = 19'($random(seed));
			rw.monitor_select = 1'h1;
			rw.phase_polarity = i[0];
			rw.target_select = 1'h1;
			refPer = i[1] ? 28 : 20;
			cmpPer = (i[1] || i[2]) ? 20 : 28;
			dir = i[0] ^ i[1];
			sendW(rw);
			window(40);
			window(560);
			chk(revCnt, 32'h0, "reverse pump");
			chk(i == 4 ? fwdCnt == 0 : fwdCnt > 0, 32'h1, "pump sense");
			chk((i != 4 && !dir) ? phR > 0 : phR == 0, 32'h1, "ref comparator");
			chk(dir ? phP > 0 : phP == 0, 32'h1, "cmp comparator");
			w = 19'(560 / (i[0] ? refPer : cmpPer));
			chk(monRise + 1 >= w && monRise <= w + 1, 32'h1, "monitor freq");
		end
		$display("test polarity done");
		refPer = 20;
		cmpPer = 28;
		pump_output_enable <= 1'h0;
		window(5);
		window(200);
		chk(fwdCnt + revCnt, 32'h0, "pump disabled");
		pump_output_enable <= 1'h1;
		rw.monitor_select = 1'h0;
		sendW(rw);
		// lock detect is on the monitor pin as save is entered
		power_save_n <= 1'h0;
		window(5);
		window(200);
		chk(fwdCnt + revCnt, 32'h0, "pump in save");
		chk(monitorOut, 32'h1, "lock in save");
		xfer(1'h0, `PDC_ADR_STATUS, 32'h0);
		chk(rd[`PDC_ST_SAVE], 32'h1, "save again");
		$display("test power save done");
		complete_run();
	end

	// watchdog well beyond the few thousand cycles the tests need
	initial begin
		#1000000;
		err_count++;
		complete_run();
	end
endmodule : test_pdc_top

`default_nettype wire
